// ==== src/loop_call_timing.sv ====
// call output timing and mode logic of a single-channel loop detector
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "loop_consts.svh"
module loop_call_timing import loop_pkg::*; #(
  parameter int MS_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // loop front end
  input  wire logic        vehicle_present,
  input  wire logic        loop_fail,
  input  wire logic [15:0] inductance_uh,
  input  wire logic [15:0] delta_l,
  output logic             osc_enable_q,
  output logic [3:0]       sens_level_q,
  output logic [2:0]       loop_freq_q,
  // controller side
  input  wire logic        phase_active,
  output logic             call_out_q,
  // display and self reset
  output logic             marker_call_q,
  output logic             marker_off_q,
  output logic [15:0]      readout_q,
  output logic             detector_reset_q
);
  cfg_if cf ();
  det_state_t  state_q, state_d;
  logic [15:0] div_q;
  logic        tick_q, phase_q, blink_q;
  logic [8:0]  blink_ms_q;
  logic [9:0]  tmr_a_q, sub_a_q, maxp_lim;
  logic [7:0]  ext_q;
  logic [6:0]  sub_b_q, pulse_q;
  logic [10:0] dwell_q, hold_q;
  logic [15:0] peak_q, remain;
  logic [1:0]  diag_on_q;
  logic        forced_call, chan_off, veh, maxp_on, sync_eff, ext_ok, phase_fell;
  logic        ld_delay, ld_maxp, ld_ext, ld_pulse, auto_rst;

  loop_regs u_regs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .c       (cf.regs)
  );

  // common 1 ms tick from the system clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 16'h0;
      tick_q <= 1'b0;
    end else if (div_q == 16'(MS_CYCLES - 1)) begin
      div_q <= 16'h0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h1;
      tick_q <= 1'b0;
    end
  end

  // mode decode; codes above off read as off
  assign forced_call = cf.sens == `SENS_CALL;
  assign chan_off = cf.sens >= `SENS_OFF;
  assign veh = vehicle_present && !forced_call && !chan_off;
  assign maxp_lim = cf.maxp_s > `MAXP_MAX ? `MAXP_MAX : cf.maxp_s;
  assign maxp_on = maxp_lim != 10'h0;
  assign sync_eff = cf.green_end_reset_sync && maxp_on;
  assign ext_ok = cf.ext_ds != 8'h0 && (!cf.gated_ext || phase_active);
  assign phase_fell = phase_q && !phase_active;

  // detector state sequence
  always_comb begin
    state_d = state_q;
    ld_delay = 1'b0;
    ld_maxp = 1'b0;
    ld_ext = 1'b0;
    ld_pulse = 1'b0;
    auto_rst = 1'b0;
    if (forced_call || chan_off) begin
      state_d = ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (veh) begin
          if (cf.pulse_mode) begin
            state_d = ST_DETECT;
            ld_pulse = 1'b1;
          end else if (cf.delay_s != 8'h0 && !phase_active) begin
            state_d = ST_DELAY;
            ld_delay = 1'b1;
          end else begin
            state_d = ST_DETECT;
            ld_maxp = 1'b1;
          end
        end
        ST_DELAY: if (!veh) begin
          state_d = ST_IDLE;
        end else if (phase_active || tmr_a_q == 10'h0) begin
          state_d = ST_DETECT;
          ld_maxp = 1'b1;
        end
        ST_DETECT: if (cf.pulse_mode) begin
          if (!veh) state_d = ST_IDLE;
          else if (dwell_q >= `DWELL_MS) state_d = ST_TUNED;
        end else if (!veh) begin
          if (ext_ok) begin
            state_d = ST_EXTEND;
            ld_ext = 1'b1;
          end else begin
            state_d = ST_IDLE;
          end
        end else if (maxp_on && tmr_a_q == 10'h0) begin
          if (sync_eff) begin
            state_d = ST_WAIT;
          end else begin
            state_d = ST_TUNED;
            auto_rst = 1'b1;
          end
        end
        ST_EXTEND: if (veh) begin
          state_d = ST_DETECT;
        end else if (ext_q == 8'h0 || (cf.gated_ext && !phase_active)) begin
          state_d = ST_IDLE;
        end
        ST_WAIT: if (!veh) begin
          state_d = ST_IDLE;
        end else if (phase_fell && !loop_fail) begin
          state_d = ST_TUNED;
          auto_rst = 1'b1;
        end
        ST_TUNED: if (!veh) state_d = ST_IDLE;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // state and phase history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      phase_q <= 1'b0;
      detector_reset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_active;
      detector_reset_q <= auto_rst;
    end
  end

  // seconds timer shared by call delay and max presence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_a_q <= 10'h0;
      sub_a_q <= 10'h0;
    end else if (ld_delay) begin
      tmr_a_q <= {2'h0, cf.delay_s};
      sub_a_q <= 10'h0;
    end else if (ld_maxp) begin
      tmr_a_q <= maxp_lim;
      sub_a_q <= 10'h0;
    end else if (state_q == ST_DELAY && phase_active) begin
      tmr_a_q <= 10'h0;
    end else if (tick_q && tmr_a_q != 10'h0 && state_q inside {ST_DELAY, ST_DETECT, ST_EXTEND}) begin
      if (sub_a_q == `SEC_MS - 10'h1) begin
        sub_a_q <= 10'h0;
        tmr_a_q <= tmr_a_q - 10'h1;
      end else begin
        sub_a_q <= sub_a_q + 10'h1;
      end
    end
  end

  // extension timer in tenths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q <= 8'h0;
      sub_b_q <= 7'h0;
    end else if (ld_ext) begin
      ext_q <= cf.ext_ds;
      sub_b_q <= 7'h0;
    end else if (tick_q && state_q == ST_EXTEND && ext_q != 8'h0) begin
      if (sub_b_q == `TENTH_MS - 7'h1) begin
        sub_b_q <= 7'h0;
        ext_q <= ext_q - 8'h1;
      end else begin
        sub_b_q <= sub_b_q + 7'h1;
      end
    end
  end

  // pulse width and dwell timers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q <= 7'h0;
      dwell_q <= 11'h0;
    end else if (ld_pulse) begin
      pulse_q <= `PULSE_MS;
      dwell_q <= 11'h0;
    end else begin
      if (forced_call || chan_off) pulse_q <= 7'h0;
      else if (tick_q && pulse_q != 7'h0) pulse_q <= pulse_q - 7'h1;
      if (tick_q && state_q == ST_DETECT && dwell_q < `DWELL_MS) dwell_q <= dwell_q + 11'h1;
    end
  end

  // call output and front-end controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      call_out_q <= 1'b0;
      osc_enable_q <= 1'b0;
      sens_level_q <= 4'h0;
      loop_freq_q <= 3'h0;
    end else begin
      if (forced_call) call_out_q <= 1'b1;
      else if (chan_off) call_out_q <= 1'b0;
      else if (cf.pulse_mode) call_out_q <= pulse_q != 7'h0;
      else call_out_q <= state_q inside {ST_DETECT, ST_EXTEND, ST_WAIT};
      osc_enable_q <= !(forced_call || chan_off);
      sens_level_q <= (forced_call || chan_off) ? 4'h0 : cf.sens;
      loop_freq_q <= cf.freq;
    end
  end

  // flashing markers for forced call and channel off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_ms_q <= 9'h0;
      blink_q <= 1'b0;
      marker_call_q <= 1'b0;
      marker_off_q <= 1'b0;
    end else begin
      if (tick_q) begin
        if (blink_ms_q == `BLINK_MS - 9'h1) begin
          blink_ms_q <= 9'h0;
          blink_q <= !blink_q;
        end else begin
          blink_ms_q <= blink_ms_q + 9'h1;
        end
      end
      marker_call_q <= forced_call && blink_q;
      marker_off_q <= chan_off && blink_q;
    end
  end

  // readout options, each switching itself off after 15 minutes
  generate
    for (genvar g = 0; g < 2; g++) begin : g_diag
      logic [19:0] on_ms_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          diag_on_q[g] <= 1'b0;
          on_ms_q <= 20'h0;
        end else if (cf.diag_wr) begin
          diag_on_q[g] <= cf.diag_val[g];
          on_ms_q <= 20'h0;
        end else if (tick_q && diag_on_q[g]) begin
          if (on_ms_q == `DIAG_OFF_MS - 20'h1) diag_on_q[g] <= 1'b0;
          on_ms_q <= on_ms_q + 20'h1;
        end
      end
    end
  endgenerate

  // peak change hold during a call
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_q <= 16'h0;
      hold_q <= 11'h0;
    end else if (diag_on_q[1] && call_out_q && (delta_l > peak_q || hold_q == 11'h0)) begin
      peak_q <= delta_l;
      hold_q <= `PEAK_MS;
    end else if (tick_q && hold_q != 11'h0) begin
      hold_q <= hold_q - 11'h1;
    end
  end

  // remaining time of the delay, extension or max presence timer, and the display word
  always_comb begin
    remain = 16'h0;
    if (state_q == ST_DELAY) remain = {6'h0, tmr_a_q};
    else if (state_q == ST_EXTEND) remain = {8'h0, ext_q};
    else if (state_q inside {ST_DETECT, ST_WAIT} && maxp_on && !cf.pulse_mode)
      remain = {6'h0, tmr_a_q};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) readout_q <= 16'h0;
    else if (diag_on_q[1]) readout_q <= peak_q;
    else if (diag_on_q[0]) readout_q <= inductance_uh;
    else readout_q <= remain;
  end

  assign cf.remain = remain;
  assign cf.readout = readout_q;
  assign cf.status = {24'h0, osc_enable_q, diag_on_q, loop_fail, call_out_q, state_q};

  // length of each call, for the pulse width check
  logic [31:0] hi_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) hi_cnt_q <= 32'h0;
    else if (call_out_q) hi_cnt_q <= hi_cnt_q + 32'h1;
    else hi_cnt_q <= 32'h0;
  end

  AST_FORCED_CALL: assert property (@(posedge aclk) disable iff (!aresetn)
    forced_call |=> call_out_q && !osc_enable_q)
    else $error("forced call did not hold the call");
  AST_CHAN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_off |=> !call_out_q && !osc_enable_q)
    else $error("channel off did not hold no call");
  AST_DELAY_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_IDLE && state_d == ST_DELAY |=> tmr_a_q == {2'h0, $past(cf.delay_s)})
    else $error("call delay not loaded at vehicle entry");
  AST_PHASE_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_DELAY && phase_active && veh
      |=> state_q != ST_DELAY && tmr_a_q == maxp_lim)
    else $error("phase active did not abort the delay");
  AST_EXT_RETURN: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_EXTEND && veh |=> state_q == ST_DETECT ##1 call_out_q)
    else $error("vehicle in extension did not return to detect");
  AST_PULSE_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    cf.pulse_mode && !forced_call && !chan_off && $fell(call_out_q) |->
      $past(hi_cnt_q) >= 32'(115 * MS_CYCLES) && $past(hi_cnt_q) <= 32'(135 * MS_CYCLES))
    else $error("pulse width out of range");
  AST_TUNE_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    cf.pulse_mode && state_q == ST_DETECT && veh && dwell_q == `DWELL_MS |=> state_q == ST_TUNED)
    else $error("long dwell not tuned out");
  AST_EMPTY_NO_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT && !vehicle_present && !forced_call && !chan_off
      |=> state_q == ST_IDLE && !detector_reset_q ##1 !call_out_q)
    else $error("empty zone in wait did not drop the call cleanly");
  AST_WAIT_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT && veh && phase_fell && !loop_fail |=> detector_reset_q ##1 !call_out_q)
    else $error("green end did not reset from wait");
  AST_FAIL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT && loop_fail |=> !detector_reset_q)
    else $error("reset despite loop failure");
  AST_SYNC_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !maxp_on && state_q == ST_DETECT |=> state_q != ST_WAIT)
    else $error("wait entered with max presence off");
  COV_PULSE: cover property (@(posedge aclk) disable iff (!aresetn) $fell(call_out_q) && cf.pulse_mode);
  COV_WAIT: cover property (@(posedge aclk) disable iff (!aresetn) state_q == ST_WAIT);
  COV_EXTEND: cover property (@(posedge aclk) disable iff (!aresetn) state_q == ST_EXTEND);
  COV_RESET: cover property (@(posedge aclk) disable iff (!aresetn) detector_reset_q);
endmodule // loop_call_timing
`default_nettype wire

// ==== src/loop_consts.svh ====
// constants of the loop call output timing block
// Operation
// - Forced call: output always calls, oscillator off, call marker flashes.
// - Channel off: output never calls, oscillator off, off marker flashes.
// - Nine sensitivity levels plus forced call and off; eight loop frequencies.
// - Call delay is 0 to 255 seconds in one-second steps.
// - Delay starts on vehicle entry; remaining delay is shown continuously.
// - Phase active high aborts delay and forces remaining delay to zero.
// - Call extension is 0 to 25.5 seconds in tenth-second steps.
// - Extension starts when zone empties; new vehicle returns to detect, restarting later.
// - Presence mode holds the call at least four minutes while occupied. The code ends it at max presence expiry, which can be set as low as 1 s.
// - Pulse mode gives one 125 +-10 ms pulse per entering vehicle.
// - Pulse mode tunes out a vehicle staying longer than two seconds.
// - Pulse mode regains full sensitivity within half a second after exit.
// - Max presence is 1 to 999 s or off; counts down from call start.
// - Zone empty before max presence expiry drops call without auto reset.
// - Without green-end sync, expiry with call present auto resets.
// - With green-end sync, expiry enters wait; empty zone drops call, no reset.
// - In wait with call present, phase active falling auto resets.
// - Green-end sync is allowed only while max presence is not off.
// - Out-of-range loop failure skips green-end reset and stays failed.
// - Both inductance readouts switch off 15 minutes after activation or power loss.
// - Change readout holds the peak change for two seconds during a call.
// - Gated extension extends only while phase active; otherwise every call extends. The code extends no pulse-mode call and no call dropped from wait.
`ifndef LOOP_CONSTS_SVH
`define LOOP_CONSTS_SVH
`define CLK_PERIOD_NS 32'h00000019
`define TICK_NS       32'h000F4240
`define SEC_MS        10'h3E8
`define TENTH_MS      7'h64
`define PULSE_MS      7'h7D
`define DWELL_MS      11'h7D0
`define PEAK_MS       11'h7D0
`define BLINK_MS      9'h1F4
`define DIAG_OFF_MS   20'hDBBA0
`define MAXP_MAX      10'h3E7
`define SENS_CALL     4'h9
`define SENS_OFF      4'hA
`define A_CTRL        8'h00
`define A_DELAY       8'h04
`define A_EXT         8'h08
`define A_MAXP        8'h0C
`define A_STAT        8'h10
`define A_REMAIN      8'h14
`define A_READOUT     8'h18
`define C_SENS        3:0
`define C_FREQ        6:4
`define C_PULSE       7
`define C_GSYNC       8
`define C_GEXT        9
`define C_DIAG        11:10
`define CTRL_MASK     32'h000003FF
`define CTRL_RST      32'h00000004
`define RESP_OK       2'h0
`define RESP_SLVERR   2'h2
`endif

// ==== src/loop_pkg.sv ====
// types of the loop call output timing block
package loop_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_DETECT, ST_EXTEND, ST_WAIT, ST_TUNED} det_state_t;
endpackage

// ==== src/cfg_if.sv ====
// settings and status between register slave and timing core
`timescale 1ns/1ps
`default_nettype none
interface cfg_if;
  logic [3:0]  sens;
  logic [2:0]  freq;
  logic        pulse_mode;
  logic        green_end_reset_sync;
  logic        gated_ext;
  logic [7:0]  delay_s;
  logic [7:0]  ext_ds;
  logic [9:0]  maxp_s;
  logic        diag_wr;
  logic [1:0]  diag_val;
  logic [31:0] status;
  logic [15:0] remain;
  logic [15:0] readout;
  modport regs (output sens, freq, pulse_mode, green_end_reset_sync, gated_ext, delay_s,
                ext_ds, maxp_s,
                diag_wr, diag_val, input status, remain, readout);
  modport core (input sens, freq, pulse_mode, green_end_reset_sync, gated_ext, delay_s,
                ext_ds, maxp_s,
                diag_wr, diag_val, output status, remain, readout);
endinterface // cfg_if
`default_nettype wire

// ==== src/loop_regs.sv ====
// axi4-lite register slave of the loop call timing block
`timescale 1ns/1ps
`default_nettype none
`include "loop_consts.svh"
module loop_regs import loop_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // settings towards the core
  cfg_if.regs              c
);
  logic [7:0]  aw_q;
  logic        aw_full_q, w_full_q;
  logic [31:0] wd_q, ctrl_q, dly_q, ext_q, maxp_q;
  logic [3:0]  ws_q;
  logic        commit, w_map, r_map;
  assign commit = aw_full_q && w_full_q && !bvalid;
  assign w_map  = aw_q <= `A_READOUT && aw_q[1:0] == 2'h0;
  assign r_map  = araddr <= `A_READOUT && araddr[1:0] == 2'h0;
  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) if (s[i]) merge[i*8 +: 8] = n[i*8 +: 8];
  endfunction
  // address and data capture in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0; wready <= 1'b0; aw_full_q <= 1'b0; w_full_q <= 1'b0;
      bvalid <= 1'b0; bresp <= `RESP_OK; aw_q <= 8'h00; wd_q <= 32'h0; ws_q <= 4'h0;
    end else begin
      if (awready && awvalid) begin
        awready <= 1'b0; aw_full_q <= 1'b1; aw_q <= awaddr;
      end else if (!aw_full_q && !bvalid) awready <= 1'b1;
      if (wready && wvalid) begin
        wready <= 1'b0; w_full_q <= 1'b1; wd_q <= wdata; ws_q <= wstrb;
      end else if (!w_full_q && !bvalid) wready <= 1'b1;
      if (commit) begin
        aw_full_q <= 1'b0; w_full_q <= 1'b0; bvalid <= 1'b1;
        bresp <= w_map ? `RESP_OK : `RESP_SLVERR;
      end else if (bvalid && bready) bvalid <= 1'b0;
    end
  end
  // writable settings; read-only words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RST; dly_q <= 32'h0; ext_q <= 32'h0; maxp_q <= 32'h0;
      c.diag_wr <= 1'b0; c.diag_val <= 2'h0;
    end else begin
      c.diag_wr <= commit && aw_q == `A_CTRL && ws_q[1];
      c.diag_val <= wd_q[`C_DIAG];
      if (commit) begin
        case (aw_q)
          `A_CTRL:  ctrl_q <= merge(ctrl_q, wd_q, ws_q) & `CTRL_MASK;
          `A_DELAY: dly_q  <= merge(dly_q, wd_q, ws_q) & 32'h000000FF;
          `A_EXT:   ext_q  <= merge(ext_q, wd_q, ws_q) & 32'h000000FF;
          `A_MAXP:  maxp_q <= merge(maxp_q, wd_q, ws_q) & 32'h000003FF;
          default: ;
        endcase
      end
    end
  end
  assign c.sens = ctrl_q[`C_SENS];
  assign c.freq = ctrl_q[`C_FREQ];
  assign c.pulse_mode = ctrl_q[`C_PULSE];
  assign c.green_end_reset_sync = ctrl_q[`C_GSYNC];
  assign c.gated_ext = ctrl_q[`C_GEXT];
  assign c.delay_s = dly_q[7:0];
  assign c.ext_ds = ext_q[7:0];
  assign c.maxp_s = maxp_q[9:0];
  // read channel, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h0; rresp <= `RESP_OK;
    end else if (arready && arvalid) begin
      arready <= 1'b0; rvalid <= 1'b1; rresp <= r_map ? `RESP_OK : `RESP_SLVERR;
      case (araddr)
        `A_CTRL:    rdata <= ctrl_q;
        `A_DELAY:   rdata <= dly_q;
        `A_EXT:     rdata <= ext_q;
        `A_MAXP:    rdata <= maxp_q;
        `A_STAT:    rdata <= c.status;
        `A_REMAIN:  rdata <= {16'h0, c.remain};
        `A_READOUT: rdata <= {16'h0, c.readout};
        default:    rdata <= 32'h0;
      endcase
    end else if (rvalid && rready) rvalid <= 1'b0;
    else if (!rvalid) arready <= 1'b1;
  end
endmodule // loop_regs
`default_nettype wire

// ==== sim/green_ctrl_model.sv ====
// controller model that drives the phase active line
`timescale 1ns/1ps
`default_nettype none
module green_ctrl_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // phase request from the bench
  input  wire logic green_req,
  output var  logic phase_active
);
  // phase changes only on a clock edge, low after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) phase_active <= 1'b0;
    else phase_active <= green_req;
  end
endmodule // green_ctrl_model
`default_nettype wire

// ==== sim/loop_call_timing_tb.sv ====
// self-checking bench of the loop call timing block
`timescale 1ns/1ps
`default_nettype none
`include "loop_consts.svh"
module loop_call_timing_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, veh, green_req;
  logic        phase_active, osc, call, rst_q, lf;
  logic [15:0] ro;
  int          rst_cnt;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb, sens;
  logic [2:0]  freq;
  logic [1:0]  bresp, rresp, rsp;
  int          err_total, tests_run;
  loop_call_timing #(.MS_CYCLES(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .vehicle_present(veh), .loop_fail(lf),
    .inductance_uh(16'h0123), .delta_l(16'h0045), .osc_enable_q(osc),
    .sens_level_q(sens), .loop_freq_q(freq), .phase_active(phase_active),
    .call_out_q(call), .marker_call_q(), .marker_off_q(), .readout_q(ro),
    .detector_reset_q(rst_q));
  green_ctrl_model u_ctrl (.aclk(aclk), .aresetn(aresetn), .green_req(green_req),
    .phase_active(phase_active));
  // clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // count self reset pulses
  always @(posedge aclk) begin
    if (!aresetn) rst_cnt <= 0;
    else if (rst_q === 1'b1) rst_cnt <= rst_cnt + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    cyc(40000);
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    veh = 1'b0; green_req = 1'b0; lf = 1'b0; err_total = 0; tests_run = 0;
    cyc(4);
    aresetn <= 1'b1;
    axi_rd(`A_CTRL); chk(rv, 32'h00000004);
    axi_rd(8'hFC); chk({30'h0, rsp}, 32'h00000002);
    axi_wr(`A_CTRL, 32'h00000009); veh <= 1'b0; cyc(5); chk({call, osc}, 32'h2);
    veh <= 1'b1; axi_wr(`A_CTRL, 32'h0000000A); cyc(5); chk({call, osc}, 32'h0);
    veh <= 1'b0; axi_wr(`A_CTRL, 32'h00000078); cyc(5);
    chk({osc, freq, sens}, 32'h000000F8);
    axi_wr(`A_DELAY, 32'h00000001); veh <= 1'b1; cyc(2000); chk(call, 32'h0);
    green_req <= 1'b1; cyc(10); chk(call, 32'h1);
    veh <= 1'b0; green_req <= 1'b0; cyc(20);
    axi_wr(`A_DELAY, 32'h0); axi_wr(`A_CTRL, 32'h00000084);
    veh <= 1'b1; cyc(10); chk(call, 32'h1);
    cyc(470); chk(call, 32'h1);
    cyc(40); chk(call, 32'h0);
    veh <= 1'b0; cyc(10);
    axi_wr(`A_CTRL, 32'h00000104); axi_wr(`A_MAXP, 32'h00000001);
    green_req <= 1'b1; veh <= 1'b1; cyc(4200); chk(call, 32'h1);
    chk(rst_cnt, 32'h0);
    green_req <= 1'b0; cyc(20); chk(rst_cnt, 32'h1);
    veh <= 1'b0; cyc(10); veh <= 1'b1; green_req <= 1'b1; cyc(4200);
    lf <= 1'b1; green_req <= 1'b0; cyc(20); chk(rst_cnt, 32'h1);
    chk(call, 32'h1);
    lf <= 1'b0; veh <= 1'b0; cyc(10); chk(call, 32'h0);
    axi_wr(`A_CTRL, 32'h00000004); veh <= 1'b1; cyc(10);
    axi_rd(`A_REMAIN); chk(rv, 32'h00000001);
    chk({16'h0, ro}, 32'h00000001);
    cyc(4200); chk(rst_cnt, 32'h2);
    chk(call, 32'h0);
    veh <= 1'b0; cyc(10);
    axi_wr(`A_MAXP, 32'h0); axi_wr(`A_EXT, 32'h00000001);
    veh <= 1'b1; cyc(10); veh <= 1'b0; cyc(200); chk(call, 32'h1);
    veh <= 1'b1; cyc(10); veh <= 1'b0; cyc(300); chk(call, 32'h1);
    cyc(150); chk(call, 32'h0);
    axi_wr(`A_CTRL, 32'h00000204);
    veh <= 1'b1; cyc(10); veh <= 1'b0; cyc(10); chk(call, 32'h0);
    axi_wr(`A_CTRL, 32'h00000404); cyc(5); chk({16'h0, ro}, 32'h00000123);
    wrap_up();
  end
endmodule // loop_call_timing_tb
`default_nettype wire
